// File: dv/chipset_model.sv
// Chipset-side model: completes acknowledge transactions and core state saving.
// Assumes the controller's level requests and one-cycle completion pulses.
`timescale 1ns/1ps
module chipset_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic txn_valid,
  input wire logic save_state_req,
  input wire logic [3:0] delay,
  output logic txn_done,
  output logic state_saved
);
  int count;
  logic done_seen;
  initial begin
    txn_done = 1'b0;
    state_saved = 1'b0;
    count = 0;
    done_seen = 1'b0;
  end
  // Falling edge drive keeps answers clear of the sampling edge
  always @(negedge clock) begin
    txn_done <= 1'b0;
    state_saved <= save_state_req && count >= delay;
    if (!rst_n || !(txn_valid || save_state_req) || state_saved) begin
      count <= 0;
      done_seen <= 1'b0;
    end else if (txn_valid && !done_seen && count >= delay) begin
      txn_done <= 1'b1;
      done_seen <= 1'b1;
    end else begin
      count <= count + 1;
    end
  end
endmodule : chipset_model

// File: dv/tb.sv
// Self-checking bench for the power-state controller.
// Assumes the chipset model answers acknowledges; pins change on falling edges.
`timescale 1ns/1ps
module tb;
  import lps_pkg::*;
  logic clock, rst_n, stop_n, sleep_n, deep_n, mgmt_n, handler_exit, state_saved, txn_done;
  logic snoop_enable, interrupt_enable, execute_enable, management_mode, save_state_req;
  logic txn_valid, power_status_indicator_n, outputs_oe;
  logic [3:0] delay;
  clock_gates_s clock_gates;
  bus_txn_e txn_type;
  power_state_e power_state;
  int miscompares, comparisons, cycles;

  low_power_state_control i_low_power_state_control (.clock(clock), .rst_n(rst_n),
    .stop_clock_request_n(stop_n), .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n),
    .mgmt_interrupt_n(mgmt_n), .state_saved(state_saved), .txn_done(txn_done),
    .handler_exit(handler_exit), .clock_gates(clock_gates), .snoop_enable(snoop_enable),
    .interrupt_enable(interrupt_enable), .execute_enable(execute_enable),
    .management_mode(management_mode), .save_state_req(save_state_req), .txn_valid(txn_valid),
    .txn_type(txn_type), .power_status_indicator_n(power_status_indicator_n),
    .outputs_oe(outputs_oe), .power_state(power_state));
  chipset_model i_chipset_model (.clock(clock), .rst_n(rst_n), .txn_valid(txn_valid),
    .save_state_req(save_state_req), .delay(delay), .txn_done(txn_done), .state_saved(state_saved));

  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    comparisons++;
    if (seen !== expected) begin
      miscompares++;
      $display("FAIL t=%0t seen=%0h expected=%0h", $time, seen, expected);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic wait_state(input power_state_e s);
    int i;
    i = 0;
    while (power_state !== s && i < 20) begin
      settle(1);
      i++;
    end
    check(8'(power_state), 8'(s));
  endtask : wait_state
  // Gates, snoop, interrupt, execute, status indicator
  function automatic logic [7:0] outs();
    return {clock_gates, snoop_enable, interrupt_enable, execute_enable, power_status_indicator_n};
  endfunction : outs
  task automatic do_reset(input int edges, input logic mgmt);
    @(negedge clock);
    rst_n = 1'b0;
    mgmt_n = mgmt;
    repeat (edges) @(negedge clock);
    rst_n = 1'b1;
    settle(3);
  endtask : do_reset
  task automatic test_stop_grant();
    @(negedge clock);
    stop_n = 1'b0;
    settle(1);
    check(8'(power_state), 8'(ST_NORMAL));
    wait_state(ST_STOP_GRANT);
    check(outs(), 8'h7D);
    check(8'({txn_valid, txn_type}), 8'h05);
    for (int i = 0; i < 20 && txn_valid !== 1'b0; i++) settle(1);
    check(8'(txn_valid), 8'h00);
  endtask : test_stop_grant
  task automatic test_sleep();
    @(negedge clock);
    sleep_n = 1'b0;
    wait_state(ST_SLEEP);
    check(outs(), 8'h11);
    @(negedge clock);
    mgmt_n = 1'b0;
    settle(6);
    check(8'(power_state), 8'(ST_SLEEP));
    @(negedge clock);
    mgmt_n = 1'b1;
    deep_n = 1'b0;
    wait_state(ST_DEEP_SLEEP);
    check(8'(power_status_indicator_n), 8'h00);
    @(negedge clock);
    deep_n = 1'b1;
    wait_state(ST_SLEEP);
    check(8'(power_status_indicator_n), 8'h01);
    @(negedge clock);
    sleep_n = 1'b1;
    wait_state(ST_STOP_GRANT);
    check(outs(), 8'h7D);
    @(negedge clock);
    stop_n = 1'b1;
    wait_state(ST_NORMAL);
    check(outs(), 8'hFF);
  endtask : test_sleep
  task automatic test_mgmt();
    @(negedge clock);
    mgmt_n = 1'b0;
    wait_state(ST_MGMT_SAVE);
    check(8'({management_mode, save_state_req, txn_valid}), 8'h06);
    @(negedge clock);
    mgmt_n = 1'b1;
    wait_state(ST_MGMT_ACK);
    check(8'({management_mode, txn_valid, txn_type}), 8'h0E);
    wait_state(ST_MGMT_RUN);
    check(8'({management_mode, txn_valid}), 8'h02);
    @(negedge clock);
    handler_exit = 1'b1;
    @(negedge clock);
    handler_exit = 1'b0;
    wait_state(ST_NORMAL);
    check(outs(), 8'hFF);
  endtask : test_mgmt
  task automatic test_strap();
    do_reset(1, 1'b0);
    check(8'(outputs_oe), 8'h00);
    do_reset(8, 1'b1);
    check(8'(outputs_oe), 8'h01);
  endtask : test_strap

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles >= 3000) begin
        miscompares++;
        close_out();
      end
    end
  end
  initial begin
    {stop_n, sleep_n, deep_n, mgmt_n} = 4'hF;
    rst_n = 1'b0;
    handler_exit = 1'b0;
    delay = 4'h3;
    miscompares = 0;
    comparisons = 0;
    do_reset(8, 1'b1);
    check(8'({outputs_oe, txn_valid}), 8'h02);
    check(outs(), 8'hFF);
    test_stop_grant();
    test_sleep();
    delay = 4'h6;
    test_mgmt();
    test_strap();
    close_out();
  end
endmodule : tb

// File: rtl/low_power_state_control.sv
// Power-state controller: Normal, Stop-Grant, Sleep, Deep Sleep, management mode.
// Assumes sideband pins are asynchronous and the bus clock runs throughout.
//
// How it works
// - Stop-Grant plus sleep request enters Sleep
// - Sleep gates all clocks but the PLL
// - Sleep ignores snoops and interrupts
// - Sleep reacts only to reset, sleep removal, deep-sleep request
// - Sleep removal returns to Stop-Grant, clocks restart
// - Deep-sleep request in Sleep enters Deep Sleep
// - Management interrupt accepted asynchronously, in Normal only
// - Management entry saves state, acknowledges, runs handler
// - Management interrupt at reset release tristates outputs
// - Stop-clock request enters Stop-Grant, acknowledges
// - Stop-Grant keeps only bus, interrupt and PLL clocks
// - Stop-Grant keeps snooping and servicing interrupts
// - Stop-clock removal restarts all clocks, resumes
// - Stop-clock asynchronous, bus clock unaffected
// - Power-status indicator asserted in Deep Sleep
`timescale 1ns/1ps
module low_power_state_control
  import lps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stop_clock_request_n,
  input wire logic sleep_request_n,
  input wire logic deep_sleep_request_n,
  input wire logic mgmt_interrupt_n,
  input wire logic state_saved,
  input wire logic txn_done,
  input wire logic handler_exit,
  output clock_gates_s clock_gates,
  output logic snoop_enable,
  output logic interrupt_enable,
  output logic execute_enable,
  output logic management_mode,
  output logic save_state_req,
  output logic txn_valid,
  output bus_txn_e txn_type,
  output logic power_status_indicator_n,
  output logic outputs_oe,
  output power_state_e power_state
);

  logic [3:0] sync_n;
  sideband_s req;

  // Raw pins go through two flops; nothing reads the first stage
  sideband_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({stop_clock_request_n, sleep_request_n, deep_sleep_request_n, mgmt_interrupt_n}),
    .sync_out(sync_n)
  );

  always_comb begin
    req = ~sync_n;
  end

  power_state_e state;
  power_state_e next_state;
  power_state_e resume_state;
  power_state_e next_resume_state;
  logic tristate;
  logic next_tristate;
  logic [1:0] strap_count;
  logic [1:0] next_strap_count;
  logic released;
  logic mgmt_seen;
  logic next_mgmt_seen;
  logic ack_pending;
  logic next_ack_pending;

  // Synchroniser restarts from idle, so the pin level at the release edge
  // only reaches req two edges later; capture the strap there, not earlier.
  always_comb begin
    next_strap_count = strap_count;
    next_tristate = tristate;
    released = (strap_count == STRAP_DONE);
    if (!released) begin
      next_strap_count = strap_count + 2'h1;
    end
    if (strap_count == STRAP_EDGES) begin
      next_tristate = req.mgmt_int;
    end
  end

  always_comb begin
    next_state = state;
    next_resume_state = resume_state;
    next_mgmt_seen = mgmt_seen & req.mgmt_int;
    next_ack_pending = ack_pending;
    if (ack_pending && txn_done) begin
      next_ack_pending = 1'b0;
    end
    unique case (state)
      ST_NORMAL: begin
        if (req.mgmt_int && !mgmt_seen && released) begin
          next_state = ST_MGMT_SAVE;
          next_resume_state = ST_NORMAL;
          next_mgmt_seen = 1'b1;
        end else if (req.stop_clock) begin
          next_state = ST_STOP_GRANT;
          next_ack_pending = 1'b1;
        end
      end
      ST_STOP_GRANT: begin
        if (!req.stop_clock) begin
          next_state = ST_NORMAL;
        end else if (req.sleep && !ack_pending) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Only sleep removal and deep-sleep are seen here
        if (!req.sleep) begin
          next_state = ST_STOP_GRANT;
        end else if (req.deep_sleep) begin
          next_state = ST_DEEP_SLEEP;
        end
      end
      ST_DEEP_SLEEP: begin
        if (!req.deep_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      ST_MGMT_SAVE: begin
        if (state_saved) begin
          next_state = ST_MGMT_ACK;
          next_ack_pending = 1'b1;
        end
      end
      ST_MGMT_ACK: begin
        if (ack_pending && txn_done) begin
          next_state = ST_MGMT_RUN;
        end
      end
      ST_MGMT_RUN: begin
        if (handler_exit) begin
          next_state = resume_state;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_NORMAL;
      resume_state <= ST_NORMAL;
      tristate <= RESET_TRISTATE;
      strap_count <= 2'h0;
      mgmt_seen <= 1'b0;
      ack_pending <= 1'b0;
    end else begin
      state <= next_state;
      resume_state <= next_resume_state;
      tristate <= next_tristate;
      strap_count <= next_strap_count;
      mgmt_seen <= next_mgmt_seen;
      ack_pending <= next_ack_pending;
    end
  end

  always_comb begin
    clock_gates = '{core: 1'b1, bus_unit: 1'b1, intr_ctrl: 1'b1, pll: 1'b1};
    snoop_enable = 1'b1;
    interrupt_enable = 1'b1;
    execute_enable = 1'b1;
    unique case (state)
      ST_STOP_GRANT: begin
        clock_gates.core = 1'b0;
        snoop_enable = 1'b1;
        interrupt_enable = 1'b1;
        execute_enable = 1'b0;
      end
      ST_SLEEP, ST_DEEP_SLEEP: begin
        clock_gates = '{core: 1'b0, bus_unit: 1'b0, intr_ctrl: 1'b0, pll: 1'b1};
        snoop_enable = 1'b0;
        interrupt_enable = 1'b0;
        execute_enable = 1'b0;
      end
      ST_MGMT_SAVE, ST_MGMT_ACK: begin
        execute_enable = 1'b0;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    power_state = state;
    management_mode = (state == ST_MGMT_SAVE) || (state == ST_MGMT_ACK) || (state == ST_MGMT_RUN);
    save_state_req = (state == ST_MGMT_SAVE);
    txn_valid = ack_pending;
    txn_type = !ack_pending ? TXN_NONE : (state == ST_MGMT_ACK ? TXN_MGMT_ACK : TXN_STOP_GRANT_ACK);
    power_status_indicator_n = !(state == ST_DEEP_SLEEP);
    outputs_oe = !tristate;
  end

  a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_STOP_GRANT && req.stop_clock && req.sleep && !ack_pending |=> state == ST_SLEEP)
    else $error("sleep not entered");
  a_sleep_gates: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_SLEEP |-> !clock_gates.core && !clock_gates.bus_unit && clock_gates.pll)
    else $error("sleep gating wrong");
  a_sleep_deaf: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_SLEEP |-> !snoop_enable && !interrupt_enable)
    else $error("sleep accepts events");
  a_sleep_exits: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_SLEEP |=> state inside {ST_SLEEP, ST_STOP_GRANT, ST_DEEP_SLEEP})
    else $error("illegal sleep exit");
  a_sleep_wake: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_SLEEP && !req.sleep |=> state == ST_STOP_GRANT ##0 clock_gates.bus_unit)
    else $error("sleep wake failed");
  a_deep_entry: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_SLEEP && req.sleep && req.deep_sleep |=> state == ST_DEEP_SLEEP)
    else $error("deep sleep not entered");
  a_mgmt_ack: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_MGMT_ACK |-> txn_valid && txn_type == TXN_MGMT_ACK)
    else $error("mgmt ack missing");
  a_mgmt_order: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(state == ST_MGMT_RUN) |-> $past(state) == ST_MGMT_ACK)
    else $error("handler before ack");
  a_tristate_strap: assert property (@(posedge clock) disable iff (!rst_n)
    strap_count == STRAP_EDGES |=> outputs_oe == !$past(req.mgmt_int))
    else $error("strap tristate wrong");
  a_tristate_hold: assert property (@(posedge clock) disable iff (!rst_n)
    released |=> $stable(outputs_oe))
    else $error("tristate changed after strap");
  a_stop_grant: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_NORMAL && req.stop_clock && !req.mgmt_int |=> state == ST_STOP_GRANT && txn_valid)
    else $error("stop grant not entered");
  a_stop_gates: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_STOP_GRANT |-> !clock_gates.core && clock_gates.bus_unit && clock_gates.intr_ctrl
      && snoop_enable && interrupt_enable)
    else $error("stop grant gating wrong");
  a_stop_exit: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_STOP_GRANT && !req.stop_clock |=> clock_gates.core && execute_enable)
    else $error("stop clock exit failed");
  a_psi: assert property (@(posedge clock) disable iff (!rst_n)
    power_status_indicator_n == (state != ST_DEEP_SLEEP))
    else $error("psi wrong");
  a_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
    ##2 1'b1 |-> sync_n[3] == $past(stop_clock_request_n, 2))
    else $error("sync latency wrong");

  c_stop_grant: cover property (@(posedge clock) disable iff (!rst_n) state == ST_STOP_GRANT);
  c_sleep: cover property (@(posedge clock) disable iff (!rst_n) state == ST_SLEEP);
  c_deep: cover property (@(posedge clock) disable iff (!rst_n) state == ST_DEEP_SLEEP);
  c_mgmt: cover property (@(posedge clock) disable iff (!rst_n) state == ST_MGMT_RUN);

endmodule : low_power_state_control

// File: rtl/lps_pkg.sv
// Shared types and constants for the low-power state controller.
// Assumes a single bus clock domain at 100 MHz.
package lps_pkg;

  localparam int SYNC_STAGES = 2;
  localparam logic RESET_TRISTATE = 1'h0;
  // Edges after reset release until the synchroniser shows the release-edge pin level
  localparam logic [1:0] STRAP_EDGES = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_STOP_GRANT,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_MGMT_SAVE,
    ST_MGMT_ACK,
    ST_MGMT_RUN
  } power_state_e;

  // Sideband request levels, active high after synchronising
  typedef struct packed {
    logic stop_clock;
    logic sleep;
    logic deep_sleep;
    logic mgmt_int;
  } sideband_s;

  // Clock gate enables per unit group
  typedef struct packed {
    logic core;
    logic bus_unit;
    logic intr_ctrl;
    logic pll;
  } clock_gates_s;

  typedef enum logic [1:0] {
    TXN_NONE,
    TXN_STOP_GRANT_ACK,
    TXN_MGMT_ACK
  } bus_txn_e;

endpackage : lps_pkg

// File: rtl/sideband_sync.sv
// Two-flop synchroniser bank for the asynchronous sideband inputs.
// Assumes inputs are raw pins; outputs are in the bus clock domain.
`timescale 1ns/1ps
module sideband_sync
  import lps_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Reset value all ones: inputs are active low, idle is deasserted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : sideband_sync
